// *** dcsc_ctrl.sv ***
`timescale 1ns/1ps
`include "dcsc_map.svh"
// Operation
// - A precharge waits max(4 cycles, 7.5 ns) after a read.
// - A read waits max(4 cycles, 7.5 ns) after a write.
// - Two mode register sets are at least 4 cycles apart.
// - Other commands wait max(floor, 15 ns) after a mode register set.
// - Reads and writes are at least 4 cycles apart.
// - One recovery cycle follows leaving multi-purpose register mode.
// - With 1KB pages, activates are max(4 cycles, 6 ns) apart.
// - With 2KB pages, activates are max(4 cycles, 7.5 ns) apart.
// - With 1KB pages, at most four activates in 37.5 ns or 30 ns.
// - With 2KB pages, at most four activates in 50 ns or 45 ns.
// - After write with auto-precharge, bank is busy for write recovery plus precharge.
module dcsc_ctrl #(
  parameter int RL = 6,
  parameter int BL = 8,
  parameter int T_RP_PS = 15000
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic link_ck,
  input wire logic req_valid,
  input wire dcsc_pkg::dcsc_cmd_type req_cmd,
  input wire logic page_2k,
  input wire logic fast_bin,
  output logic req_ready,
  output logic cmd_valid_r,
  output dcsc_pkg::dcsc_cmd_type cmd_out_r,
  output logic strobe_window_r
);
  // ==========================================
  // Derived cycle counts
  localparam int CP = `DCSC_CLK_PS;
  localparam int C_RTP = dcsc_pkg::dcsc_cyc(`DCSC_T_RTP_PS, CP, `DCSC_CK_FLOOR);
  localparam int C_WTR = dcsc_pkg::dcsc_cyc(`DCSC_T_WTR_PS, CP, `DCSC_CK_FLOOR);
  localparam int C_MOD = dcsc_pkg::dcsc_cyc(`DCSC_T_MOD_PS, CP, `DCSC_MOD_FLOOR);
  localparam int C_RRD1 = dcsc_pkg::dcsc_cyc(`DCSC_T_RRD1K_PS, CP, `DCSC_CK_FLOOR);
  localparam int C_RRD2 = dcsc_pkg::dcsc_cyc(`DCSC_T_RRD2K_PS, CP, `DCSC_CK_FLOOR);
  localparam int C_F1S = dcsc_pkg::dcsc_cyc(`DCSC_T_FAW1K_SLOW_PS, CP, 1);
  localparam int C_F1F = dcsc_pkg::dcsc_cyc(`DCSC_T_FAW1K_FAST_PS, CP, 1);
  localparam int C_F2S = dcsc_pkg::dcsc_cyc(`DCSC_T_FAW2K_SLOW_PS, CP, 1);
  localparam int C_F2F = dcsc_pkg::dcsc_cyc(`DCSC_T_FAW2K_FAST_PS, CP, 1);
  localparam int C_WRA = dcsc_pkg::dcsc_cyc(`DCSC_T_WR_PS, CP, 1)
                       + dcsc_pkg::dcsc_cyc(T_RP_PS, CP, 1);
  localparam int W = 8;
  initial begin
    if (RL < 2 || RL > 60 || (BL != 4 && BL != 8) || C_WRA > 250) begin
      $error("dcsc_ctrl: unsupported parameters");
    end
  end
  // ==========================================
  // Link clock sampling, two stages then edge detect
  logic ck_s1_r, ck_s2_r, ck_s3_r;
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      ck_s1_r <= 1'b0;
      ck_s2_r <= 1'b0;
      ck_s3_r <= 1'b0;
    end else begin
      ck_s1_r <= link_ck;
      ck_s2_r <= ck_s1_r;
      ck_s3_r <= ck_s2_r;
    end
  end
  logic tick;
  assign tick = ck_s2_r & ~ck_s3_r;
  // ==========================================
  // Spacing counters, one per constraint, in link cycles
  localparam int N = 8;
  logic [N-1:0] rdy;
  logic [N-1:0] start;
  logic [W-1:0] load [N];
  logic issue;
  dcsc_pkg::dcsc_cmd_type c;
  assign c = req_cmd;
  assign issue = req_valid & req_ready;
  // 0 RTP, 1 WTR, 2 MRD, 3 MOD, 4 CCD, 5 MPRR, 6 RRD, 7 WRA busy
  always_comb begin
    start = '0;
    start[0] = issue && c == dcsc_pkg::DCSC_RD;
    start[1] = issue && (c == dcsc_pkg::DCSC_WR || c == dcsc_pkg::DCSC_WRA);
    start[2] = issue && c == dcsc_pkg::DCSC_MRS;
    start[3] = issue && c == dcsc_pkg::DCSC_MRS;
    start[4] = issue && (c == dcsc_pkg::DCSC_RD || c == dcsc_pkg::DCSC_WR
                         || c == dcsc_pkg::DCSC_WRA);
    start[5] = issue && c == dcsc_pkg::DCSC_MPX;
    start[6] = issue && c == dcsc_pkg::DCSC_ACT;
    start[7] = issue && c == dcsc_pkg::DCSC_WRA;
  end
  assign load[0] = W'(C_RTP);
  assign load[1] = W'(C_WTR);
  assign load[2] = W'(`DCSC_MRD_CK);
  assign load[3] = W'(C_MOD);
  assign load[4] = W'(`DCSC_CCD_CK);
  assign load[5] = W'(`DCSC_MPRR_CK);
  assign load[6] = page_2k ? W'(C_RRD2) : W'(C_RRD1);
  assign load[7] = W'(C_WRA);
  // Counters decrement once per link cycle via start/tick gating
  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_cnt
      // Ready again exactly load ticks after the start
      dcsc_cnt #(.W(W)) u_cnt (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .start(start[gi]),
        .step(tick),
        .load(load[gi]),
        .ready(rdy[gi])
      );
    end
  endgenerate
  // ==========================================
  // Four-activate window: age of last four activates
  logic [W-1:0] faw_age_r [4];
  logic [W-1:0] faw_age_nxt [4];
  logic [W-1:0] faw_len;
  always_comb begin
    if (page_2k) begin
      faw_len = fast_bin ? W'(C_F2F) : W'(C_F2S);
    end else begin
      faw_len = fast_bin ? W'(C_F1F) : W'(C_F1S);
    end
    for (int i = 0; i < 4; i++) begin
      faw_age_nxt[i] = faw_age_r[i];
      if (tick && faw_age_r[i] != '0) begin
        faw_age_nxt[i] = faw_age_r[i] - 1'b1;
      end
    end
    if (start[6]) begin
      for (int i = 3; i > 0; i--) begin
        faw_age_nxt[i] = faw_age_nxt[i-1];
      end
      faw_age_nxt[0] = faw_len;
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      for (int i = 0; i < 4; i++) begin
        faw_age_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        faw_age_r[i] <= faw_age_nxt[i];
      end
    end
  end
  logic faw_ok;
  assign faw_ok = (faw_age_r[3] == '0);
  // ==========================================
  // Admission of a command, one per link tick
  logic ok;
  always_comb begin
    ok = rdy[5];
    unique case (c)
      dcsc_pkg::DCSC_NOP: ok = 1'b1;
      dcsc_pkg::DCSC_MRS: ok = ok & rdy[2] & rdy[7];
      dcsc_pkg::DCSC_PRE: ok = ok & rdy[0] & rdy[3] & rdy[7];
      dcsc_pkg::DCSC_RD: ok = ok & rdy[1] & rdy[3] & rdy[4];
      dcsc_pkg::DCSC_WR, dcsc_pkg::DCSC_WRA: ok = ok & rdy[3] & rdy[4] & rdy[7];
      dcsc_pkg::DCSC_ACT: ok = ok & rdy[3] & rdy[6] & rdy[7] & faw_ok;
      dcsc_pkg::DCSC_MPX: ok = ok & rdy[3];
      default: ok = 1'b0;
    endcase
  end
  assign req_ready = tick & ok;
  // ==========================================
  // Issued command register and strobe window tracking
  logic cmd_valid_nxt;
  dcsc_pkg::dcsc_cmd_type cmd_out_nxt;
  logic [W-1:0] rl_cnt_r, rl_cnt_nxt;
  logic strobe_window_nxt;
  localparam int RD_END = RL + BL / 2;
  always_comb begin
    cmd_valid_nxt = issue;
    cmd_out_nxt = issue ? c : dcsc_pkg::DCSC_NOP;
    rl_cnt_nxt = rl_cnt_r;
    if (issue && c == dcsc_pkg::DCSC_RD) begin
      rl_cnt_nxt = W'(1);
    end else if (tick && rl_cnt_r != '0) begin
      rl_cnt_nxt = (rl_cnt_r >= W'(RD_END)) ? '0 : rl_cnt_r + 1'b1;
    end
    // Strobe expected from RL-1 up to RL+BL/2
    strobe_window_nxt = (rl_cnt_nxt >= W'(RL)) && (rl_cnt_nxt != '0);
  end
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      cmd_valid_r <= 1'b0;
      cmd_out_r <= dcsc_pkg::DCSC_NOP;
      rl_cnt_r <= '0;
      strobe_window_r <= 1'b0;
    end else begin
      cmd_valid_r <= cmd_valid_nxt;
      cmd_out_r <= cmd_out_nxt;
      rl_cnt_r <= rl_cnt_nxt;
      strobe_window_r <= strobe_window_nxt;
    end
  end
  // ==========================================
  // Checks
  a_mrd_spacing: assert property (@(posedge core_clk) disable iff (!rst_b)
    (issue && c == dcsc_pkg::DCSC_MRS) |=> !(issue && c == dcsc_pkg::DCSC_MRS) [*8])
    else $error("mode register sets too close");
  a_ccd_spacing: assert property (@(posedge core_clk) disable iff (!rst_b)
    (issue && c == dcsc_pkg::DCSC_RD) |=> !(issue && c == dcsc_pkg::DCSC_RD) [*8])
    else $error("column commands too close");
  a_ready_tick: assert property (@(posedge core_clk) disable iff (!rst_b)
    req_ready |-> tick)
    else $error("command admitted off tick");
  a_faw_block: assert property (@(posedge core_clk) disable iff (!rst_b)
    (faw_age_r[3] != '0) |-> !(issue && c == dcsc_pkg::DCSC_ACT))
    else $error("fifth activate inside window");
  a_rtp_block: assert property (@(posedge core_clk) disable iff (!rst_b)
    !rdy[0] |-> !(issue && c == dcsc_pkg::DCSC_PRE))
    else $error("precharge too soon after read");
  a_wtr_block: assert property (@(posedge core_clk) disable iff (!rst_b)
    !rdy[1] |-> !(issue && c == dcsc_pkg::DCSC_RD))
    else $error("read too soon after write");
  a_mod_block: assert property (@(posedge core_clk) disable iff (!rst_b)
    !rdy[3] |-> !(issue && c == dcsc_pkg::DCSC_ACT))
    else $error("activate too soon after mode set");
  a_rrd_block: assert property (@(posedge core_clk) disable iff (!rst_b)
    !rdy[6] |-> !(issue && c == dcsc_pkg::DCSC_ACT))
    else $error("activates too close");
  a_wra_block: assert property (@(posedge core_clk) disable iff (!rst_b)
    (issue && c == dcsc_pkg::DCSC_WRA) |=> !rdy[7])
    else $error("auto-precharge busy not started");
endmodule // dcsc_ctrl

// *** dcsc_map.svh ***
`ifndef DCSC_MAP_SVH
`define DCSC_MAP_SVH
// ==========================================
// Timing figures
`define DCSC_T_RTP_PS 7500
`define DCSC_T_WTR_PS 7500
`define DCSC_T_MOD_PS 15000
`define DCSC_T_RRD1K_PS 6000
`define DCSC_T_RRD2K_PS 7500
`define DCSC_T_FAW1K_SLOW_PS 37500
`define DCSC_T_FAW1K_FAST_PS 30000
`define DCSC_T_FAW2K_SLOW_PS 50000
`define DCSC_T_FAW2K_FAST_PS 45000
`define DCSC_T_WR_PS 15000
`define DCSC_CK_FLOOR 4
`define DCSC_MRD_CK 4
`define DCSC_CCD_CK 4
`define DCSC_MOD_FLOOR 12
`define DCSC_MPRR_CK 1
`define DCSC_CLK_PS 100000
`endif

// *** dcsc_pkg.sv ***
package dcsc_pkg;
  // ==========================================
  // Command codes
  typedef enum logic [2:0] {
    DCSC_NOP = 3'h0, DCSC_ACT = 3'h1, DCSC_RD = 3'h2, DCSC_WR = 3'h3,
    DCSC_PRE = 3'h4, DCSC_MRS = 3'h5, DCSC_WRA = 3'h6, DCSC_MPX = 3'h7
  } dcsc_cmd_type;
  // Returns cycles for a ps minimum, rounded up, with a floor
  function automatic int dcsc_cyc(input int ps, input int clk_ps, input int floor_ck);
    int c;
    c = (ps + clk_ps - 1) / clk_ps;
    return (c > floor_ck) ? c : floor_ck;
  endfunction
endpackage

// *** dcsc_cnt.sv ***
`timescale 1ns/1ps
// ==========================================
// Down counter stepped by an enable, ready when zero
module dcsc_cnt #(
  parameter int W = 8
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic step,
  input wire logic [W-1:0] load,
  output logic ready
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  // Next count; load less one so ready comes on the load-th step
  always_comb begin
    cnt_nxt = cnt_r;
    if (start) begin
      cnt_nxt = (load != '0) ? load - 1'b1 : '0;
    end else if (step && cnt_r != '0) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end
  // Register
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
  assign ready = (cnt_r == '0);
endmodule // dcsc_cnt

// *** dcsc_dev.sv ***
`timescale 1ns/1ps
// ==========================================
// Device side model: read strobe drive window
module dcsc_dev #(
  parameter int RL = 6,
  parameter int BL = 8
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic link_ck,
  input wire logic cmd_valid_r,
  input wire dcsc_pkg::dcsc_cmd_type cmd_out_r,
  output logic strobe_oe_b
);
  int lk_cnt = 0;
  int rd_tick = -100;
  // Counts command clock rises
  always @(posedge link_ck) lk_cnt <= lk_cnt + 1;
  // Notes the tick of each read
  always @(posedge core_clk) begin
    if (!rst_b) rd_tick <= -100;
    else if (cmd_valid_r && cmd_out_r == dcsc_pkg::DCSC_RD) rd_tick <= lk_cnt;
  end
  // Preamble from RL-1, release at RL+BL/2
  assign strobe_oe_b = !((lk_cnt - rd_tick >= RL - 1) &&
                         (lk_cnt - rd_tick < RL + BL / 2));
endmodule // dcsc_dev

// *** dcsc_ctrl_bench.sv ***
`timescale 1ns/1ps
// ==========================================
// Bench for the command spacing block
module dcsc_ctrl_bench;
  localparam int RL = 6;
  localparam int BL = 8;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic link_ck = 1'b0;
  logic req_valid = 1'b0;
  dcsc_pkg::dcsc_cmd_type req_cmd = dcsc_pkg::DCSC_NOP;
  logic page_2k = 1'b0;
  logic fast_bin = 1'b0;
  logic req_ready;
  logic cmd_valid_r;
  dcsc_pkg::dcsc_cmd_type cmd_out_r;
  logic strobe_window_r;
  logic strobe_oe_b;
  int n_errors = 0;
  int cmp_count = 0;
  int tick_cnt = 0;
  int cyc = 0;
  // Clocks: core 100 ns, command clock 800 ns with odd phase
  always #50 core_clk = ~core_clk;
  initial begin
    #137;
    forever #400 link_ck = ~link_ck;
  end
  always @(posedge link_ck) tick_cnt <= tick_cnt + 1;
  dcsc_ctrl #(.RL(RL), .BL(BL)) dut (
    .core_clk(core_clk), .rst_b(rst_b), .link_ck(link_ck), .req_valid(req_valid),
    .req_cmd(req_cmd), .page_2k(page_2k), .fast_bin(fast_bin), .req_ready(req_ready),
    .cmd_valid_r(cmd_valid_r), .cmd_out_r(cmd_out_r), .strobe_window_r(strobe_window_r)
  );
  dcsc_dev #(.RL(RL), .BL(BL)) dev (
    .core_clk(core_clk), .rst_b(rst_b), .link_ck(link_ck), .cmd_valid_r(cmd_valid_r),
    .cmd_out_r(cmd_out_r), .strobe_oe_b(strobe_oe_b)
  );
  // ==========================================
  // Shared tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %0t %h %h", $time, got, exp);
    end
  endtask
  // Holds a request until taken, returns the tick of the take
  task automatic issue(input dcsc_pkg::dcsc_cmd_type c, output int t);
    int w;
    w = 0;
    @(posedge core_clk);
    req_valid <= 1'b1;
    req_cmd <= c;
    @(negedge core_clk);
    while (req_ready !== 1'b1 && w < 400) begin
      @(negedge core_clk);
      w++;
    end
    if (w >= 400) n_errors++;
    @(posedge core_clk);
    t = tick_cnt;
    req_valid <= 1'b0;
    req_cmd <= dcsc_pkg::DCSC_NOP;
    @(negedge core_clk);
    chk(8'(cmd_valid_r), 8'h01);
    chk(8'(cmd_out_r), 8'(c));
  endtask
  // Two commands back to back, spacing in ticks must be exact
  task automatic gap(input dcsc_pkg::dcsc_cmd_type a, input dcsc_pkg::dcsc_cmd_type b,
                     input int n);
    int t0;
    int t1;
    issue(a, t0);
    issue(b, t1);
    chk(8'(t1 - t0), 8'(n));
  endtask
  // ==========================================
  // Scenarios
  task automatic sc_read_paths();
    gap(dcsc_pkg::DCSC_RD, dcsc_pkg::DCSC_PRE, 4);
    gap(dcsc_pkg::DCSC_WR, dcsc_pkg::DCSC_RD, 4);
    gap(dcsc_pkg::DCSC_RD, dcsc_pkg::DCSC_WR, 4);
  endtask
  task automatic sc_mode_set();
    gap(dcsc_pkg::DCSC_MRS, dcsc_pkg::DCSC_MRS, 4);
    gap(dcsc_pkg::DCSC_MRS, dcsc_pkg::DCSC_ACT, 12);
  endtask
  // Five activates per page size and bin; window never exceeds spacing here
  task automatic sc_activates();
    int t0;
    int t1;
    for (int m = 0; m < 4; m++) begin
      page_2k <= m[0];
      fast_bin <= m[1];
      issue(dcsc_pkg::DCSC_ACT, t0);
      for (int k = 0; k < 4; k++) begin
        issue(dcsc_pkg::DCSC_ACT, t1);
        chk(8'(t1 - t0), 8'h04);
        t0 = t1;
      end
    end
  endtask
  task automatic sc_recovery();
    gap(dcsc_pkg::DCSC_MPX, dcsc_pkg::DCSC_RD, 1);
    gap(dcsc_pkg::DCSC_WRA, dcsc_pkg::DCSC_PRE, 2);
  endtask
  // Strobe window opens RL-1 ticks after the read, closes at RL+BL/2
  task automatic sc_strobe();
    int t0;
    int t1;
    int w;
    w = 0;
    issue(dcsc_pkg::DCSC_RD, t0);
    while (strobe_window_r !== 1'b1 && w < 200) begin
      @(negedge core_clk);
      w++;
    end
    t1 = tick_cnt;
    chk(8'(t1 - t0), 8'(RL - 1));
    chk(8'(strobe_oe_b), 8'h00);
    while (strobe_window_r !== 1'b0 && w < 400) begin
      @(negedge core_clk);
      w++;
    end
    chk(8'(tick_cnt - t1), 8'(BL / 2 + 1));
  endtask
  // ==========================================
  // Verdict and run control
  task automatic end_of_test();
    if (n_errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_errors++;
      end_of_test();
    end
  end
  initial begin
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (40) @(posedge core_clk);
    sc_read_paths();
    sc_mode_set();
    sc_activates();
    sc_recovery();
    sc_strobe();
    end_of_test();
  end
endmodule // dcsc_ctrl_bench
